// ### src/pmi_top.sv
// Purpose: pulse measurement, input interrupts and periodic timer over APB
// Assumes: 100 MHz pclk; scan engine on the same clock
// Notes:   registers answer with no wait state
//
// The placing of the registers and the APB slave port are this design's own decisions.
`include "pmi_regs.svh"
module pmi_top #(
    parameter int MS_CYCLES = `PMI_MS_CYC,
    parameter int PTI_W     = 16
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // digital pins
    input  wire logic [7:0]  din,
    output logic      [7:0]  dout,
    // scan engine
    input  wire logic        scan_refresh,
    input  wire logic        svc_done,
    output logic             svc_start,
    output logic             svc_active,
    output logic      [2:0]  svc_id,
    // special function state
    output logic      [1:0]  qc_enable,
    output logic      [3:0]  meas_active
);
    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    localparam int PRE_W = 17;

    if (MS_CYCLES < 1 || MS_CYCLES >= (1 << PRE_W))
    begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end
    if (PTI_W < 1 || PTI_W > 32)
    begin : g_bad_pti
        $error("PTI_W out of range");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic                    pready;
        logic                    pslverr;
        logic [31:0]             prdata;
        logic                    tenth;
        logic [3:0]              pm_en;
        logic [1:0]              qc_en;
        logic [3:0]              int_en;
        logic [3:0]              int_rise;
        logic [3:0]              meas_on;
        logic [PTI_W-1:0]        pti_ms;
        logic [PTI_W-1:0]        pti_cnt;
        logic [PRE_W-1:0]        pti_pre;
        logic [4:0]              pend;
        pmi_pkg::pmi_svc_st_type svc_st;
        pmi_pkg::pmi_svc_id_type svc_id;
        logic                    svc_start;
        logic [6:0]              tick_pre;
        logic                    tick;
        logic [7:0]              in_img;
        logic [7:0]              out_img;
        logic [7:0]              dout;
    } pmi_top_st_type;

    pmi_top_st_type st_ff, nxt_st;

    logic [31:0] width_w  [4];
    logic [31:0] period_w [4];
    logic [31:0] freq_w   [4];
    logic [3:0]  rise_ch, fall_ch, ev;
    logic [3:0]  qc_map;
    logic        mapped, wr_acc, pti_ev;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // input synchroniser and channels
    // ----------------------------------------
    pmi_edge_if #(.W(8)) edge_bus ();

    pmi_sync #(.W(8)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (din),
        .edge_o  (edge_bus)
    );

    for (genvar c = 0; c < 4; c++)
    begin : g_ch
        pmi_meas #(.CH(`PMI_SPECIAL_LSB + c)) u_meas (
            .pclk    (pclk),
            .presetn (presetn),
            .enable  (st_ff.meas_on[c]),
            .tick    (st_ff.tick),
            .tenth   (st_ff.tenth),
            .edge_i  (edge_bus),
            .width   (width_w[c]),
            .period  (period_w[c]),
            .freq    (freq_w[c])
        );
    end

    // ----------------------------------------
    // edge events and decode
    // ----------------------------------------
    assign rise_ch = edge_bus.rise[`PMI_SPECIAL_LSB +: 4];
    assign fall_ch = edge_bus.fall[`PMI_SPECIAL_LSB +: 4];
    assign ev      = st_ff.int_en & ((rise_ch & st_ff.int_rise) | (fall_ch & ~st_ff.int_rise));
    // pair counter maps onto both inputs
    assign qc_map  = {st_ff.qc_en[1], st_ff.qc_en[1], st_ff.qc_en[0], st_ff.qc_en[0]};
    assign wr_acc  = psel & penable & pwrite & st_ff.pready & mapped;
    assign pti_ev  = (st_ff.pti_ms != '0) && (st_ff.pti_pre == PRE_W'(MS_CYCLES - 1))
                     && (st_ff.pti_cnt == st_ff.pti_ms - PTI_W'(1));

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = `PMI_RST_WORD;
        unique case (paddr)
            `PMI_OFF_MODE:    rd_mux[`PMI_MODE_TENTH] = st_ff.tenth;
            `PMI_OFF_PM_EN:   rd_mux[3:0] = st_ff.pm_en;
            `PMI_OFF_QC_DEF:  rd_mux[1:0] = st_ff.qc_en;
            `PMI_OFF_INT_DEF: rd_mux[7:0] = {st_ff.int_rise, st_ff.int_en};
            `PMI_OFF_PTI:     rd_mux[PTI_W-1:0] = st_ff.pti_ms;
            `PMI_OFF_SVC:
            begin
                rd_mux[4:0]           = st_ff.pend;
                rd_mux[`PMI_SVC_BUSY] = (st_ff.svc_st == pmi_pkg::PMI_SVC_BUSY);
            end
            `PMI_OFF_IN_IMG:  rd_mux[7:0] = st_ff.in_img;
            `PMI_OFF_OUT_IMG: rd_mux[7:0] = st_ff.out_img;
            default:          mapped = 1'b0;
        endcase
        // result words, three per channel: width, period, frequency
        for (int n = 0; n < 4; n++)
        begin
            if (paddr == `PMI_OFF_WIDTH0 + 8'(n) * `PMI_REG_STRIDE)
            begin
                rd_mux = width_w[n];
                mapped = 1'b1;
            end
            if (paddr == `PMI_OFF_PERIOD0 + 8'(n) * `PMI_REG_STRIDE)
            begin
                rd_mux = period_w[n];
                mapped = 1'b1;
            end
            if (paddr == `PMI_OFF_FREQ0 + 8'(n) * `PMI_REG_STRIDE)
            begin
                rd_mux = freq_w[n];
                mapped = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.svc_start = 1'b0;

        // apb: answer latched in setup, ready in access
        if (psel && !penable)
        begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = ~mapped;
            nxt_st.prdata  = mapped ? rd_mux : `PMI_RST_WORD;
        end
        else
        begin
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
        end

        // register writes at the access edge
        if (wr_acc)
        begin
            unique case (paddr)
                `PMI_OFF_MODE:
                begin
                    nxt_st.tenth = pwdata[`PMI_MODE_TENTH];
                end
                `PMI_OFF_PM_EN:
                begin
                    nxt_st.pm_en = pwdata[3:0];
                    if (|pwdata[1:0]) nxt_st.qc_en[0] = 1'b0;
                    if (|pwdata[3:2]) nxt_st.qc_en[1] = 1'b0;
                    // new measurement use ends interrupt use
                    nxt_st.int_en = st_ff.int_en & ~pwdata[3:0];
                end
                `PMI_OFF_QC_DEF:
                begin
                    // counter only from its own define
                    nxt_st.qc_en = pwdata[1:0];
                    if (pwdata[0]) nxt_st.int_en[1:0] = 2'b00;
                    if (pwdata[1]) nxt_st.int_en[3:2] = 2'b00;
                end
                `PMI_OFF_INT_DEF:
                begin
                    nxt_st.int_en   = pwdata[3:0];
                    nxt_st.int_rise = pwdata[`PMI_INT_EDGE_LSB +: 4];
                    // interrupt use ends counter and measurement
                    nxt_st.pm_en    = st_ff.pm_en & ~pwdata[3:0];
                    if (|pwdata[1:0]) nxt_st.qc_en[0] = 1'b0;
                    if (|pwdata[3:2]) nxt_st.qc_en[1] = 1'b0;
                end
                `PMI_OFF_PTI:
                begin
                    nxt_st.pti_ms  = pwdata[PTI_W-1:0];
                    nxt_st.pti_cnt = '0;
                    nxt_st.pti_pre = '0;
                end
                `PMI_OFF_OUT_IMG:
                begin
                    nxt_st.out_img = pwdata[7:0];
                end
                default:
                begin
                    nxt_st.out_img = st_ff.out_img;
                end
            endcase
        end

        nxt_st.meas_on = (st_ff.pm_en | qc_map) & ~st_ff.int_en;

        // count unit tick, one microsecond or tenth
        nxt_st.tick = 1'b0;
        if (st_ff.tick_pre == 7'((st_ff.tenth ? `PMI_TENTH_CYC : `PMI_US_CYC) - 1))
        begin
            nxt_st.tick_pre = '0;
            nxt_st.tick     = 1'b1;
        end
        else
        begin
            nxt_st.tick_pre = st_ff.tick_pre + 7'h01;
        end

        if (st_ff.pti_ms != '0 && !(wr_acc && paddr == `PMI_OFF_PTI))
        begin
            if (st_ff.pti_pre == PRE_W'(MS_CYCLES - 1))
            begin
                nxt_st.pti_pre = '0;
                if (pti_ev) nxt_st.pti_cnt = '0;
                else        nxt_st.pti_cnt = st_ff.pti_cnt + PTI_W'(1);
            end
            else
            begin
                nxt_st.pti_pre = st_ff.pti_pre + PRE_W'(1);
            end
        end

        // output image reaches pins at refresh
        if (scan_refresh)
        begin
            nxt_st.in_img = edge_bus.lvl;
            nxt_st.dout   = st_ff.out_img;
        end

        // service arbitration: timer first, then lowest input
        unique case (st_ff.svc_st)
            pmi_pkg::PMI_SVC_IDLE:
            begin
                if (st_ff.pend[4])
                begin
                    nxt_st.pend[4]   = 1'b0;
                    nxt_st.svc_id    = pmi_pkg::PMI_ID_PTI;
                    nxt_st.svc_st    = pmi_pkg::PMI_SVC_BUSY;
                    nxt_st.svc_start = 1'b1;
                end
                // pending input edge starts routine when no timer event is pending
                else if (|st_ff.pend[3:0])
                begin
                    for (int k = 3; k >= 0; k--)
                    begin
                        if (st_ff.pend[k])
                        begin
                            nxt_st.svc_id = pmi_pkg::pmi_svc_id_type'(3'(k));
                        end
                    end
                    nxt_st.pend[nxt_st.svc_id[1:0]] = 1'b0;
                    nxt_st.svc_st    = pmi_pkg::PMI_SVC_BUSY;
                    nxt_st.svc_start = 1'b1;
                end
            end
            pmi_pkg::PMI_SVC_BUSY:
            begin
                if (svc_done) nxt_st.svc_st = pmi_pkg::PMI_SVC_IDLE;
            end
        endcase

        // new events set pending; set wins over clear
        nxt_st.pend = nxt_st.pend | {pti_ev, ev};
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff        <= '0;
            st_ff.svc_st <= pmi_pkg::PMI_SVC_IDLE;
            st_ff.svc_id <= pmi_pkg::PMI_ID_IN0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // outputs, all from flops
    // ----------------------------------------
    assign prdata      = st_ff.prdata;
    assign pready      = st_ff.pready;
    assign pslverr     = st_ff.pslverr;
    assign dout        = st_ff.dout;
    assign svc_start   = st_ff.svc_start;
    assign svc_active  = (st_ff.svc_st == pmi_pkg::PMI_SVC_BUSY);
    assign svc_id      = st_ff.svc_id;
    assign qc_enable   = st_ff.qc_en;
    assign meas_active = st_ff.meas_on;
    // one count unit resolution covers 10 kHz
endmodule // pmi_top

// ### src/pmi_regs.svh
// Purpose: register offsets, field positions and timing counts of the pulse block
// Assumes: 100 MHz pclk, byte addresses on an 8-bit APB address
// Notes:   definitions only
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PMI_CLK_PERIOD_NS  10
`define PMI_US_NS          1000
`define PMI_TENTH_US_NS    100
`define PMI_MS_NS          1000000
`define PMI_US_CYC         (`PMI_US_NS / `PMI_CLK_PERIOD_NS)
`define PMI_TENTH_CYC      (`PMI_TENTH_US_NS / `PMI_CLK_PERIOD_NS)
`define PMI_MS_CYC         (`PMI_MS_NS / `PMI_CLK_PERIOD_NS)
`define PMI_HZ_US          24'hF4240
`define PMI_HZ_TENTH       24'h989680
`define PMI_DIV_STEPS      5'h18
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMI_OFF_MODE       8'h00
`define PMI_OFF_PM_EN      8'h04
`define PMI_OFF_QC_DEF     8'h08
`define PMI_OFF_INT_DEF    8'h0C
`define PMI_OFF_PTI        8'h10
`define PMI_OFF_SVC        8'h14
`define PMI_OFF_WIDTH0     8'h18
`define PMI_OFF_PERIOD0    8'h28
`define PMI_OFF_FREQ0      8'h38
`define PMI_OFF_IN_IMG     8'h48
`define PMI_OFF_OUT_IMG    8'h4C
`define PMI_REG_STRIDE     8'h04
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PMI_MODE_TENTH     0
`define PMI_INT_EDGE_LSB   4
`define PMI_SVC_BUSY       8
`define PMI_SPECIAL_LSB    2
`define PMI_RST_WORD       32'h0000_0000
`endif

// ### src/pmi_pkg.sv
// Purpose: types shared by the pulse measurement and interrupt block
// Assumes: pmi_regs.svh holds every number
// Notes:   state of each module but pmi_sync is one packed struct
package pmi_pkg;
    typedef enum logic [2:0] {
        PMI_ID_IN0 = 3'h0,
        PMI_ID_IN1 = 3'h1,
        PMI_ID_IN2 = 3'h2,
        PMI_ID_IN3 = 3'h3,
        PMI_ID_PTI = 3'h4
    } pmi_svc_id_type;
    typedef enum logic [0:0] {
        PMI_SVC_IDLE = 1'b0,
        PMI_SVC_BUSY = 1'b1
    } pmi_svc_st_type;
    typedef struct packed {
        logic [31:0] hcnt;
        logic [31:0] pcnt;
        logic [31:0] width;
        logic [31:0] period;
        logic [31:0] freq;
        logic        seen;
        logic        busy;
        logic [4:0]  step;
        logic [23:0] quot;
        logic [32:0] rem;
    } pmi_meas_st_type;
endpackage : pmi_pkg

// ### src/pmi_edge_if.sv
// Purpose: carries synchronised levels and edge pulses of the inputs
// Assumes: one pclk domain
// Notes:   src drives, dst reads
interface pmi_edge_if #(parameter int W = 8);
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : pmi_edge_if

// ### src/pmi_sync.sv
// Purpose: three-stage synchroniser with edge pulses for the input pins
// Assumes: pins asynchronous to pclk
// Notes:   a change counts once stages two and three agree
module pmi_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins
    input  wire logic [W-1:0] pin,
    // synchronised side
    pmi_edge_if.src           edge_o
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
    logic [W-1:0] agree;

    // stages agree and differ from held level
    assign agree = ~(s2_ff ^ s3_ff) & (s3_ff ^ lvl_ff);

    // shift chain and edge pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            lvl_ff  <= '0;
            rise_ff <= '0;
            fall_ff <= '0;
        end
        else
        begin
            s1_ff   <= pin;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            lvl_ff  <= lvl_ff ^ agree;
            rise_ff <= agree & s3_ff;
            fall_ff <= agree & ~s3_ff;
        end
    end

    assign edge_o.lvl  = lvl_ff;
    assign edge_o.rise = rise_ff;
    assign edge_o.fall = fall_ff;
endmodule // pmi_sync

// ### src/pmi_meas.sv
// Purpose: one pulse measurement channel: high width, period, frequency
// Assumes: tick is one pulse per count unit
// Notes:   frequency from a serial restoring divider
`include "pmi_regs.svh"
module pmi_meas #(
    parameter int CH = 0
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        enable,
    input  wire logic        tick,
    input  wire logic        tenth,
    pmi_edge_if.dst          edge_i,
    // results
    output logic [31:0]      width,
    output logic [31:0]      period,
    output logic [31:0]      freq
);
    pmi_pkg::pmi_meas_st_type st_ff, nxt_st;
    logic [32:0] trial;

    // counting, capture and division
    always_comb
    begin
        nxt_st = st_ff;
        trial  = '0;
        if (!enable)
        begin
            nxt_st = '0;
        end
        else
        begin
            if (tick)
            begin
                if (~&st_ff.pcnt) nxt_st.pcnt = st_ff.pcnt + 32'h1;
                if (edge_i.lvl[CH] && ~&st_ff.hcnt) nxt_st.hcnt = st_ff.hcnt + 32'h1;
            end
            if (edge_i.rise[CH])
            begin
                if (st_ff.seen)
                begin
                    nxt_st.period = st_ff.pcnt;
                    nxt_st.busy   = 1'b1;
                    nxt_st.step   = `PMI_DIV_STEPS;
                    nxt_st.rem    = '0;
                    nxt_st.quot   = tenth ? `PMI_HZ_TENTH : `PMI_HZ_US;
                end
                nxt_st.pcnt = '0;
                nxt_st.hcnt = '0;
                nxt_st.seen = 1'b1;
            end
            else if (edge_i.fall[CH] && st_ff.seen)
            begin
                nxt_st.width = st_ff.hcnt;
            end
            // one quotient bit per cycle
            if (st_ff.busy && !edge_i.rise[CH])
            begin
                trial       = {st_ff.rem[31:0], st_ff.quot[23]};
                nxt_st.quot = {st_ff.quot[22:0], 1'b0};
                if (st_ff.period != '0 && trial >= {1'b0, st_ff.period})
                begin
                    trial          = trial - {1'b0, st_ff.period};
                    nxt_st.quot[0] = 1'b1;
                end
                nxt_st.rem  = trial;
                nxt_st.step = st_ff.step - 5'h1;
                if (st_ff.step == 5'h1)
                begin
                    nxt_st.busy = 1'b0;
                    nxt_st.freq = {8'h00, nxt_st.quot};
                end
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) st_ff <= '0;
        else          st_ff <= nxt_st;
    end

    assign width  = st_ff.width;
    assign period = st_ff.period;
    assign freq   = st_ff.freq;
endmodule // pmi_meas

// ### dv/pmi_top_asserts.sv
// Purpose: port checks of the pulse and interrupt block
// Assumes: one pclk domain, reset low active
// Notes:   bound from the bench top
module pmi_top_asserts (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // apb
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    // pins and engine
    input wire logic [7:0] dout,
    input wire logic       scan_refresh,
    input wire logic       svc_done,
    input wire logic       svc_start,
    input wire logic       svc_active,
    input wire logic [2:0] svc_id,
    input wire logic [1:0] qc_enable,
    input wire logic [3:0] meas_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // apb phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    AST_APB_NOWAIT: assert property (s_setup ##1 s_access |-> pready)
        else $error("access cycle without ready");
    AST_START_PULSE: assert property (svc_start |=> !svc_start)
        else $error("start longer than one cycle");
    AST_START_ACTIVE: assert property (svc_start |-> svc_active && svc_id <= 3'h4)
        else $error("start without active or bad id");
    AST_ACTIVE_CAUSE: assert property ($rose(svc_active) |-> svc_start)
        else $error("active rose without start");
    AST_BUSY_HOLD: assert property (svc_active && !svc_done |=> !svc_start)
        else $error("start while routine busy");
    AST_ID_HOLD: assert property (svc_active && !svc_start |-> $stable(svc_id))
        else $error("id changed while busy");
    AST_DONE_ENDS: assert property (svc_done && svc_active |=> !svc_active || svc_start)
        else $error("active stayed after done");
    AST_DOUT_REFRESH: assert property (!scan_refresh |=> $stable(dout))
        else $error("outputs moved without refresh");
    AST_QC_MEAS: assert property (qc_enable[0] && $past(qc_enable[0]) |-> meas_active[1:0] == 2'b11)
        else $error("counter pair without measurement");
endmodule // pmi_top_asserts

// ### dv/pmi_pulse_src.sv
// Purpose: rectangular pulse sources for the four special inputs
// Assumes: times in ns, high shorter than period
// Notes:   idle low while stopped
module pmi_pulse_src (
    // control
    input  wire logic [3:0] run,
    input  wire integer     hi_ns,
    input  wire integer     per_ns,
    // pulse outputs
    output logic      [3:0] wave
);
    timeunit 1ns;
    timeprecision 1ns;
    // one generator per channel, phases staggered off the clock
    for (genvar g = 0; g < 4; g++)
    begin : g_ch
        initial
        begin
            wave[g] = 1'b0;
            #(g * 1237 + 3);
            forever
            begin
                wait (run[g]);
                wave[g] = 1'b1;
                #(hi_ns);
                wave[g] = 1'b0;
                #(per_ns - hi_ns);
            end
        end
    end
endmodule // pmi_pulse_src

// ### dv/pulse_measure_and_input_interrupts_test.sv
// Purpose: self-checking bench of the pulse and interrupt block
// Assumes: 100 MHz pclk, one ms shortened to MS cycles
// Notes:   engine side answers done at once unless held
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module pulse_measure_and_input_interrupts_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        scan_refresh, svc_done, svc_start, svc_active, auto_done, man_done;
    logic [7:0]  paddr, din, dout;
    logic [31:0] pwdata, prdata, rd, r;
    logic [2:0]  svc_id;
    logic [1:0]  qc_enable, lo_bits, hi_bits;
    logic [3:0]  meas_active, run, wave;
    int          hi_us, per_us, n, num_errors, compares;
    assign din = {hi_bits, wave, lo_bits};
    pmi_top #(.MS_CYCLES(MS)) uut (.*);
    pmi_pulse_src u_src (.run(run), .hi_ns(hi_us * 1000), .per_ns(per_us * 1000), .wave(wave));
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // engine finishes a routine one cycle after start
    always @(posedge pclk) svc_done <= (svc_start & auto_done) | man_done;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input int lo, input int hi);
        apb(1'b0, a, 32'h0);
        `CHK(rd >= lo && rd <= hi, 1'b1)
    endtask
    task automatic wait_start(output int k);
        k = 0;
        do begin @(posedge pclk); k++; end while (svc_start !== 1'b1 && k < 3000);
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #1000000;
        num_errors++;
        close_out();
    end
    // main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, scan_refresh, man_done, run, lo_bits, hi_bits} = '0;
        {presetn, num_errors, compares, auto_done} = '0;
        auto_done = 1'b1;
        void'($urandom(32'h6277192C));
        hi_us = 3 + $urandom % 7;
        per_us = hi_us + 4 + $urandom % 10;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, 8'h7C, 32'hFFFFFFFF);
        `CHK(err, 1'b1)
        apb(1'b1, 8'h04, 32'hF);
        repeat (2) @(posedge pclk);
        `CHK({qc_enable, meas_active}, 6'h0F)
        run <= 4'hF;
        repeat (4 * per_us * 100) @(posedge pclk);
        for (int c = 0; c < 4; c++)
        begin
            chk_rd(8'h18 + 8'(4 * c), hi_us - 1, hi_us + 1);
            chk_rd(8'h28 + 8'(4 * c), per_us - 1, per_us + 1);
            chk_rd(8'h38 + 8'(4 * c), 1000000 / (per_us + 1), 1000000 / (per_us - 1));
        end
        apb(1'b1, 8'h00, 32'h1);
        repeat (4 * per_us * 100) @(posedge pclk);
        chk_rd(8'h2C, per_us * 10 - 1, per_us * 10 + 1);
        chk_rd(8'h3C, 10000000 / (per_us * 10 + 1), 10000000 / (per_us * 10 - 1));
        apb(1'b1, 8'h08, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK({qc_enable, meas_active}, 6'h1F)
        apb(1'b1, 8'h04, 32'h1);
        @(posedge pclk);
        `CHK(qc_enable, 2'b00)
        for (int e = 0; e < 2; e++)
        begin
            apb(1'b1, 8'h0C, e ? 32'h02 : 32'h11);
            repeat (10) @(posedge pclk);
            `CHK(meas_active[e], 1'b0)
            wait_start(n);
            `CHK(svc_id, 3'(e))
            `CHK(wave[e], 1'(1 - e))
        end
        auto_done <= 1'b0;
        wait_start(n);
        apb(1'b1, 8'h10, 32'h1);
        repeat (3 * MS) @(posedge pclk);
        `CHK(svc_active, 1'b1)
        man_done <= 1'b1;
        @(posedge pclk);
        man_done <= 1'b0;
        auto_done <= 1'b1;
        wait_start(n);
        `CHK(svc_id, 3'h4)
        apb(1'b1, 8'h0C, 32'h0);
        repeat (10) @(posedge pclk);
        wait_start(n);
        repeat (3)
        begin
            wait_start(n);
            `CHK({svc_id, n}, {3'h4, MS})
        end
        r = $urandom;
        apb(1'b1, 8'h4C, r);
        lo_bits <= 2'($urandom);
        hi_bits <= 2'($urandom);
        repeat (6) @(posedge pclk);
        `CHK(dout, 8'h00)
        scan_refresh <= 1'b1;
        @(posedge pclk);
        scan_refresh <= 1'b0;
        @(posedge pclk);
        `CHK(dout, r[7:0])
        apb(1'b0, 8'h48, 32'h0);
        `CHK({rd[7:6], rd[1:0]}, {hi_bits, lo_bits})
        close_out();
    end
endmodule // pulse_measure_and_input_interrupts_test
bind pmi_top pmi_top_asserts u_chk (.*);
